// [verilog/irq_ctrl_pkg.sv]
// Constants and carrier types for the two-level interrupt controller
package irq_ctrl_pkg;

    localparam int unsigned SLOT_COUNT = 17;
    localparam int unsigned IDX_W = 5;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned VEC_W = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_LEVEL = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_EXT_IRQ_ENABLE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_EXT_IRQ_LEVEL = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_EXT2_IRQ_ENABLE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_EXT2_IRQ_LEVEL = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_PEND_LOW = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_PEND_MID = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_PEND_HIGH = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_SERVICE_STAT = 4'h9;

    // Field positions
    localparam int unsigned GLOBAL_EN_BIT = 7;
    localparam int unsigned LEVEL_UNUSED_BIT = 7;
    localparam int unsigned EXT2_USED = 2;

    // Reset values
    localparam logic [DATA_W-1:0] ENABLE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] LEVEL_RESET = 8'h00;
    localparam logic [SLOT_COUNT-1:0] PEND_RESET = 17'h00000;

    // Slot 13 has no source behind it
    localparam logic [SLOT_COUNT-1:0] SLOT_PRESENT = 17'h1dfff;
    // Slots 0..3 lose their flag when the call is taken
    localparam logic [SLOT_COUNT-1:0] SLOT_HW_CLEAR = 17'h0000f;

    localparam logic [VEC_W-1:0] VECTOR_RESET = 16'h0000;
    localparam logic [VEC_W-1:0] VECTOR_BASE = 16'h0003;
    localparam int unsigned VECTOR_STRIDE_SHIFT = 3;

    // Latency figures in system clocks, kept by the core's sequencer
    localparam int unsigned DETECT_CYCLES = 1;
    localparam int unsigned CALL_CYCLES = 4;
    localparam int unsigned MIN_RESPONSE_CYCLES = DETECT_CYCLES + CALL_CYCLES;
    localparam int unsigned MAX_RESPONSE_CYCLES = 18;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic instr_done;
        logic return_from_interrupt_done;
        logic call_ack;
    } core_evt_t;

endpackage

// [verilog/two_level_irq_ctrl.sv]
// Two-level vectored interrupt controller with register port
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Source event sets its pending flag regardless of enable.
// - Enabled pending flag requests a long_call to its vector at a boundary.
// - return_from_interrupt resumes the interrupted flow; core restores, we pop level.
// - Disabled source pending flag produces no request.
// - global_irq_enable bit 7 low blocks every source.
// - Flags of slots 0 to 3 clear on vectoring; others stay for software.
// - Flag still set after return re-enters after one more instruction.
// - Software setting a pending flag acts like a hardware event.
// - Sixteen sources, each with pending, enable and level bit.
// - High level preempts low routine; nothing preempts a high routine.
// - All level bits reset to low.
// - High wins over low, then lowest order index wins.
// - Requests sampled each clock; one cycle detect plus four for the call.
// - After return with request pending, exactly one instruction runs first.
// - Worst case eighteen clocks: detect, return, divide, call.
// - Equal or lower level waits for return plus one instruction.
// - Each source vectors to its fixed address; slot 13 reserved.
// - Enable bits in enable registers, level bits in level registers.
// - Bit 7 of basic level register reads one, ignores writes.
module two_level_irq_ctrl
    import irq_ctrl_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire reg_req_t reg_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic [SLOT_COUNT-1:0] src_event_i,
    input wire core_evt_t core_i,
    output logic call_req_o,
    output logic [VEC_W-1:0] call_vector_o,
    output logic [1:0] in_service_o
);

    function automatic logic [IDX_W-1:0] first_index(input logic [SLOT_COUNT-1:0] vec);
        logic [IDX_W-1:0] idx;
        idx = '0;
        for (int i = SLOT_COUNT - 1; i >= 0; i--)
        begin
            if (vec[i])
            begin
                idx = IDX_W'(i);
            end
        end
        return idx;
    endfunction

    logic [DATA_W-1:0] en_base_r;
    logic [DATA_W-1:0] lvl_base_r;
    logic [DATA_W-1:0] en_ext_r;
    logic [DATA_W-1:0] lvl_ext_r;
    logic [EXT2_USED-1:0] en_ext2_r;
    logic [EXT2_USED-1:0] lvl_ext2_r;
    logic [SLOT_COUNT-1:0] pend_r;
    logic [SLOT_COUNT-1:0] pend_nxt;
    logic act_hi_r;
    logic act_lo_r;
    logic act_hi_nxt;
    logic act_lo_nxt;
    logic hold_r;
    logic hold_nxt;
    logic req_r;
    logic req_level_r;
    logic [IDX_W-1:0] sel_idx_r;
    logic [VEC_W-1:0] vector_r;
    logic [DATA_W-1:0] rdata_r;

    // Register decode
    wire wr_en_base = reg_i.wr && reg_i.addr == OFS_IRQ_ENABLE;
    wire wr_lvl_base = reg_i.wr && reg_i.addr == OFS_IRQ_LEVEL;
    wire wr_en_ext = reg_i.wr && reg_i.addr == OFS_EXT_IRQ_ENABLE;
    wire wr_lvl_ext = reg_i.wr && reg_i.addr == OFS_EXT_IRQ_LEVEL;
    wire wr_en_ext2 = reg_i.wr && reg_i.addr == OFS_EXT2_IRQ_ENABLE;
    wire wr_lvl_ext2 = reg_i.wr && reg_i.addr == OFS_EXT2_IRQ_LEVEL;
    wire wr_pend_low = reg_i.wr && reg_i.addr == OFS_PEND_LOW;
    wire wr_pend_mid = reg_i.wr && reg_i.addr == OFS_PEND_MID;
    wire wr_pend_high = reg_i.wr && reg_i.addr == OFS_PEND_HIGH;

    wire [SLOT_COUNT-1:0] slot_enable = {en_ext2_r, en_ext_r, en_base_r[6:0]};
    wire [SLOT_COUNT-1:0] slot_level = {lvl_ext2_r, lvl_ext_r, lvl_base_r[6:0]};

    wire global_en = en_base_r[GLOBAL_EN_BIT];
    wire ack = core_i.call_ack && req_r;

    wire [SLOT_COUNT-1:0] eligible = pend_r & slot_enable & SLOT_PRESENT
                                     & {SLOT_COUNT{global_en}};
    // Preemption: high routine blocks all, low routine admits high only
    wire [SLOT_COUNT-1:0] hi_cand = act_hi_r ? '0 : (eligible & slot_level);
    // Same or lower level waits for the routine to finish
    wire [SLOT_COUNT-1:0] lo_cand = (act_hi_r || act_lo_r) ? '0 : (eligible & ~slot_level);
    // High level first, then lowest index
    wire pick_hi = |hi_cand;
    wire [IDX_W-1:0] win_idx = pick_hi ? first_index(hi_cand) : first_index(lo_cand);
    // Hold after a return until one instruction completes
    wire win_valid = (pick_hi || |lo_cand) && !hold_r;
    wire [VEC_W-1:0] win_vector = VECTOR_BASE + VEC_W'({win_idx, 3'b000});

    // Software view of pending flags, written whole per register
    wire [SLOT_COUNT-1:0] sw_mask = {wr_pend_high, {8{wr_pend_mid}}, {8{wr_pend_low}}};
    wire [SLOT_COUNT-1:0] sw_value = {reg_i.wdata[0], reg_i.wdata, reg_i.wdata};
    // Clear only the hardware-cleared slot being vectored to
    wire [SLOT_COUNT-1:0] hw_clear = ack ? (SLOT_HW_CLEAR & (17'h00001 << sel_idx_r)) : '0;

    // Events set flags, and an event beats any clear in its cycle
    // Software writes ones the same way as events
    assign pend_nxt = src_event_i | (sw_mask & sw_value) | (~sw_mask & pend_r & ~hw_clear);

    // Level stack: entering pushes, return pops the innermost
    assign act_hi_nxt = ack ? (req_level_r || act_hi_r) : (act_hi_r && !core_i.return_from_interrupt_done);
    assign act_lo_nxt = (ack && !req_level_r) ? 1'b1 :
                        (act_lo_r && !(core_i.return_from_interrupt_done && !act_hi_r));
    // After a return, one instruction must complete before re-entry
    assign hold_nxt = core_i.return_from_interrupt_done ? 1'b1 : (hold_r && !core_i.instr_done);

    wire [DATA_W-1:0] read_mux =
        reg_i.addr == OFS_IRQ_ENABLE ? en_base_r :
        reg_i.addr == OFS_IRQ_LEVEL ? (lvl_base_r | (8'h01 << LEVEL_UNUSED_BIT)) :
        reg_i.addr == OFS_EXT_IRQ_ENABLE ? en_ext_r :
        reg_i.addr == OFS_EXT_IRQ_LEVEL ? lvl_ext_r :
        reg_i.addr == OFS_EXT2_IRQ_ENABLE ? {6'h00, en_ext2_r} :
        reg_i.addr == OFS_EXT2_IRQ_LEVEL ? {6'h00, lvl_ext2_r} :
        reg_i.addr == OFS_PEND_LOW ? pend_r[7:0] :
        reg_i.addr == OFS_PEND_MID ? pend_r[15:8] :
        reg_i.addr == OFS_PEND_HIGH ? {7'h00, pend_r[16]} :
        reg_i.addr == OFS_SERVICE_STAT ? {5'h00, hold_r, act_hi_r, act_lo_r} :
        8'h00;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            en_base_r <= ENABLE_RESET;
        else if (wr_en_base)
            en_base_r <= reg_i.wdata;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            lvl_base_r <= LEVEL_RESET;
        else if (wr_lvl_base)
            lvl_base_r <= {1'b0, reg_i.wdata[6:0]};
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            en_ext_r <= ENABLE_RESET;
        else if (wr_en_ext)
            en_ext_r <= reg_i.wdata;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            lvl_ext_r <= LEVEL_RESET;
        else if (wr_lvl_ext)
            lvl_ext_r <= reg_i.wdata;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            en_ext2_r <= '0;
        else if (wr_en_ext2)
            en_ext2_r <= reg_i.wdata[EXT2_USED-1:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            lvl_ext2_r <= '0;
        else if (wr_lvl_ext2)
            lvl_ext2_r <= reg_i.wdata[EXT2_USED-1:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            pend_r <= PEND_RESET;
            act_hi_r <= 1'b0;
            act_lo_r <= 1'b0;
            hold_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            pend_r <= pend_nxt;
            act_hi_r <= act_hi_nxt;
            act_lo_r <= act_lo_nxt;
            hold_r <= hold_nxt;
            rdata_r <= reg_i.rd ? read_mux : 8'h00;
        end
    end

    // Arbitration is re-sampled every clock; one cycle to detect
    // Request holds until the core takes it at an instruction boundary
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            req_r <= 1'b0;
            req_level_r <= 1'b0;
            sel_idx_r <= '0;
            vector_r <= VECTOR_RESET;
        end
        else
        begin
            req_r <= win_valid && !ack;
            req_level_r <= pick_hi;
            sel_idx_r <= win_idx;
            // Vector shows zero whenever no request stands
            vector_r <= (win_valid && !ack) ? win_vector : VECTOR_RESET;
        end
    end

    assign rdata_o = rdata_r;
    assign call_req_o = req_r;
    assign call_vector_o = vector_r;
    assign in_service_o = {act_hi_r, act_lo_r};

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    a_global_blocks_req: assert property (!global_en |=> !call_req_o)
        else $error("request raised while global enable was low");

    a_hold_one_instr: assert property (hold_r |=> !call_req_o)
        else $error("request raised before one instruction after return");

    a_high_not_preempted: assert property (act_hi_r |=> !call_req_o)
        else $error("request raised during a high level routine");

    a_low_admits_high: assert property (
        act_lo_r && !core_i.return_from_interrupt_done |=> !call_req_o || req_level_r)
        else $error("low request preempted a low level routine");

    a_event_sets_flag: assert property (
        src_event_i != '0 |=> (pend_r & $past(src_event_i)) == $past(src_event_i))
        else $error("source event did not set its pending flag");

    a_hw_flag_clear: assert property (
        ack && sel_idx_r < 5'h04 && src_event_i == '0 && !reg_i.wr
        |=> !pend_r[$past(sel_idx_r)])
        else $error("hardware-cleared flag survived vectoring");

    a_sw_flag_kept: assert property (
        ack && sel_idx_r >= 5'h04 |=> pend_r[$past(sel_idx_r)] || $past(reg_i.wr))
        else $error("software-cleared flag lost on vectoring");

    a_vector_form: assert property (
        call_req_o |-> call_vector_o == VECTOR_BASE + VEC_W'({sel_idx_r, 3'b000}))
        else $error("vector does not match order index");

    a_detect_one_cycle: assert property (
        win_valid && !ack |=> call_req_o && sel_idx_r == $past(win_idx))
        else $error("qualified request not raised one cycle later");

    a_level_reset_low: assert property (
        $past(reset_i) |-> slot_level == '0 && en_base_r == ENABLE_RESET)
        else $error("level bits not low after reset");

    a_unused_reads_one: assert property (
        reg_i.rd && reg_i.addr == OFS_IRQ_LEVEL |=> rdata_o[LEVEL_UNUSED_BIT])
        else $error("unused level bit did not read one");

    a_reserved_silent: assert property (
        call_req_o |-> sel_idx_r != 5'd13)
        else $error("reserved slot requested");

    a_vector_idle_zero: assert property (
        !call_req_o |-> call_vector_o == VECTOR_RESET)
        else $error("vector shown without a request");

    a_disabled_no_req: assert property (
        eligible == '0 |=> !call_req_o)
        else $error("request raised with no enabled flag");

    a_req_from_winner: assert property (
        call_req_o |-> $past(win_valid))
        else $error("request raised without a qualified winner");

    a_ack_drops_req: assert property (
        ack |=> !call_req_o)
        else $error("request still raised after the call was taken");

    a_ack_enters: assert property (
        ack |=> act_hi_r || act_lo_r)
        else $error("no routine marked active after the call");

    a_enter_low: assert property (
        ack && !req_level_r |=> act_lo_r)
        else $error("low routine not marked active");

    a_enter_high: assert property (
        ack && req_level_r |=> act_hi_r)
        else $error("high routine not marked active");

    a_return_pops_high: assert property (
        core_i.return_from_interrupt_done && act_hi_r && !ack |=> !act_hi_r)
        else $error("return did not end the high routine");

    a_return_ends_low: assert property (
        core_i.return_from_interrupt_done && !act_hi_r && act_lo_r && !ack |=> !act_lo_r)
        else $error("return did not end the low routine");

    a_return_sets_hold: assert property (
        core_i.return_from_interrupt_done |=> hold_r)
        else $error("hold not raised after a return");

    a_hold_released: assert property (
        hold_r && core_i.instr_done && !core_i.return_from_interrupt_done |=> !hold_r)
        else $error("hold kept after one instruction");

    a_sw_sets_low: assert property (
        wr_pend_low |=> pend_r[7:0] == ($past(reg_i.wdata) | $past(src_event_i[7:0])))
        else $error("software write to low flags not applied");

    a_sw_sets_mid: assert property (
        wr_pend_mid |=> pend_r[15:8] == ($past(reg_i.wdata) | $past(src_event_i[15:8])))
        else $error("software write to middle flags not applied");

    a_sw_sets_top: assert property (
        wr_pend_high |=> pend_r[16] == ($past(reg_i.wdata[0]) | $past(src_event_i[16])))
        else $error("software write to top flag not applied");

    a_en_base_stored: assert property (
        wr_en_base |=> en_base_r == $past(reg_i.wdata))
        else $error("basic enable write lost");

    a_lvl_base_stored: assert property (
        wr_lvl_base |=> lvl_base_r[6:0] == $past(reg_i.wdata[6:0]))
        else $error("basic level write lost");

    a_en_ext_stored: assert property (
        wr_en_ext |=> en_ext_r == $past(reg_i.wdata))
        else $error("extended enable write lost");

    a_lvl_ext_stored: assert property (
        wr_lvl_ext |=> lvl_ext_r == $past(reg_i.wdata))
        else $error("extended level write lost");

    a_enable_readback: assert property (
        reg_i.rd && reg_i.addr == OFS_IRQ_ENABLE |=> rdata_o == $past(en_base_r))
        else $error("enable register read back wrong");

    a_rdata_one_cycle: assert property (
        !reg_i.rd |=> rdata_o == 8'h00)
        else $error("read data stood longer than one cycle");

endmodule

`default_nettype wire

// [bench/core_model.sv]
// Behavioural core sequencer facing the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module core_model
    import irq_ctrl_pkg::*;
#(
    parameter int GAP = 3
)
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic call_req_i,
    input wire logic ack_en_i,
    input wire logic return_from_interrupt_cmd_i,
    output var core_evt_t core_o
);
    logic [3:0] gap_r;
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            core_o <= '0;
            gap_r <= 4'h0;
        end
        else
        begin
            core_o.call_ack <= call_req_i & ack_en_i & ~core_o.call_ack;
            core_o.return_from_interrupt_done <= return_from_interrupt_cmd_i;
            // Slow next instruction keeps the hold window visible
            core_o.instr_done <= (gap_r == 4'h1);
            gap_r <= return_from_interrupt_cmd_i ? 4'(GAP + 1) : gap_r - {3'h0, gap_r != 4'h0};
        end
    end
endmodule
`default_nettype wire

// [bench/two_level_irq_ctrl_tb.sv]
// Register and core-link tests of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module two_level_irq_ctrl_tb import irq_ctrl_pkg::*; ();
    logic clock, reset, ack_en, return_from_interrupt_cmd, call_req;
    reg_req_t req;
    logic [SLOT_COUNT-1:0] src;
    logic [DATA_W-1:0] rdata;
    logic [VEC_W-1:0] vec;
    logic [1:0] svc;
    core_evt_t core;
    int n_mismatch, samples_checked;
    two_level_irq_ctrl two_level_irq_ctrl_i (.clock_i(clock), .reset_i(reset), .reg_i(req),
        .rdata_o(rdata), .src_event_i(src), .core_i(core), .call_req_o(call_req),
        .call_vector_o(vec), .in_service_o(svc));
    core_model core_model_i (.clock_i(clock), .reset_i(reset), .call_req_i(call_req),
        .ack_en_i(ack_en), .return_from_interrupt_cmd_i(return_from_interrupt_cmd), .core_o(core));
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task step;
        @(posedge clock);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        cmp({24'h0, rdata}, {24'h0, e});
    endtask
    task out_chk(input logic r, input logic [15:0] v, input logic [1:0] s);
        cmp({13'h0, call_req, vec, svc}, {13'h0, r, v, s});
    endtask
    task ev(input logic [16:0] m);
        @(posedge clock);
        src <= m;
        @(posedge clock);
        src <= '0;
        #1;
    endtask
    task take;
        @(posedge clock);
        ack_en <= 1'b1;
        @(posedge clock);
        ack_en <= 1'b0;
        step;
    endtask
    // Stops in the cycle that carries the instruction after the return
    task ret;
        int k;
        @(posedge clock);
        return_from_interrupt_cmd <= 1'b1;
        @(posedge clock);
        return_from_interrupt_cmd <= 1'b0;
        k = 0;
        while (core.instr_done !== 1'b1 && k < 10)
        begin
            step;
            k++;
        end
        cmp(k, 32'd4);
    endtask
    task conclude;
        $display("counts: %0d checked, %0d wrong", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Whole run needs a few hundred cycles
    initial
    begin
        #2000000;
        n_mismatch++;
        conclude;
    end
    initial
    begin
        reset = 1'b1;
        req = '0;
        src = '0;
        ack_en = 1'b0;
        return_from_interrupt_cmd = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd_chk(OFS_IRQ_LEVEL, 8'h80);
        rd_chk(OFS_IRQ_ENABLE, 8'h00);
        wr(OFS_IRQ_LEVEL, 8'h7f);
        rd_chk(OFS_IRQ_LEVEL, 8'hff);
        wr(OFS_IRQ_LEVEL, 8'h00);
        rd_chk(4'ha, 8'h00);
        $display("test registers done");
        ev(17'h00002);
        step;
        out_chk(1'b0, 16'h0000, 2'b00);
        rd_chk(OFS_PEND_LOW, 8'h02);
        wr(OFS_IRQ_ENABLE, 8'h02);
        step;
        out_chk(1'b0, 16'h0000, 2'b00);
        wr(OFS_IRQ_ENABLE, 8'h82);
        step;
        out_chk(1'b1, 16'h000b, 2'b00);
        take;
        out_chk(1'b0, 16'h0000, 2'b01);
        ret;
        out_chk(1'b0, 16'h0000, 2'b00);
        $display("test masking done");
        wr(OFS_IRQ_ENABLE, 8'hff);
        wr(OFS_EXT_IRQ_ENABLE, 8'hff);
        wr(OFS_EXT2_IRQ_ENABLE, 8'h03);
        for (int i = 0; i < 17; i++)
        begin
            wr(4'(6 + i / 8), 8'h01 << (i % 8));
            step;
            out_chk(i != 13, (i == 13) ? 16'h0 : 16'(3 + 8 * i), 2'b00);
            if (i != 13)
                take;
            rd_chk(4'(6 + i / 8), (i < 4 && i != 13) ? 8'h00 : 8'h01 << (i % 8));
            wr(4'(6 + i / 8), 8'h00);
            if (i != 13)
                ret;
        end
        $display("test vectors done");
        wr(OFS_PEND_LOW, 8'h10);
        step;
        out_chk(1'b1, 16'h0023, 2'b00);
        take;
        out_chk(1'b0, 16'h0000, 2'b01);
        ret;
        out_chk(1'b0, 16'h0000, 2'b00);
        step;
        step;
        out_chk(1'b1, 16'h0023, 2'b00);
        take;
        wr(OFS_PEND_LOW, 8'h00);
        ret;
        $display("test reentry done");
        wr(OFS_IRQ_LEVEL, 8'h20);
        ev(17'h00029);
        out_chk(1'b0, 16'h0000, 2'b00);
        step;
        out_chk(1'b1, 16'h002b, 2'b00);
        take;
        out_chk(1'b0, 16'h0000, 2'b10);
        wr(OFS_PEND_LOW, 8'h09);
        ret;
        step;
        step;
        out_chk(1'b1, 16'h0003, 2'b00);
        take;
        ev(17'h00020);
        step;
        out_chk(1'b1, 16'h002b, 2'b01);
        take;
        out_chk(1'b0, 16'h0000, 2'b11);
        wr(OFS_PEND_LOW, 8'h08);
        ret;
        step;
        step;
        out_chk(1'b0, 16'h0000, 2'b01);
        ret;
        step;
        step;
        out_chk(1'b1, 16'h001b, 2'b00);
        take;
        ret;
        $display("test priority done");
        conclude;
    end
endmodule
`default_nettype wire
